// ===== hdl/crbi_regs.sv
// Summary of operation
// - Header word is ROM quadlet at 400h.
// - Header at 18h, RW, upper half resets zero.
// - Header fields: info, CRC length, CRC value.
// - EEPROM present loads the CRC field.
// - Without EEPROM, CRC reset value is undefined.
// - Read-only 1394 constant at 1Ch, bus info.
// - Options at 20h, second bus info quadlet.
// - Options reset X0XX A0X2h, 27-24 read zero.
// - Bits 31-28 writable capability flags.
// - Bits 23-16 writable clock accuracy.
// - max_rec size 2^(n+1), at least 512; host writes are taken unclamped.
// - Hard reset max_rec 2048, soft reset keeps.
`default_nettype none
module crbi_regs
  import crbi_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire crbi_host_req_t host_req,
  output var  logic [31:0]    host_rdata,
  output var  logic           host_ack,
  output var  logic           host_err,
  input  wire logic           soft_rst,
  input  wire logic           eeprom_load,
  input  wire logic [15:0]    eeprom_crc,
  input  wire logic           rom_rd,
  input  wire logic [7:0]     rom_quad,
  output var  logic [31:0]    rom_rdata,
  output var  logic           rom_ack,
  output var  logic           rom_hit,
  output var  logic [31:0]    rom_header_out,
  output var  logic [31:0]    bus_options_out
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [31:0] rom_header_word;       // Header: info, crc len, crc
  logic [31:0] bus_options_word;      // Bus options, writable bits
  logic [31:0] next_rom_header_word;  // Next header
  logic [31:0] next_bus_options_word; // Next options
  logic [31:0] next_host_rdata;       // Next read data
  logic        next_host_ack;         // Next access strobe
  logic        next_host_err;         // Next unmapped flag
  logic [7:0]  quad;                  // Offset mapped to quadlet
  logic [32:0] sel;                   // Read selection with hit
  crbi_words_t words;                 // Live words for both readers
  logic [31:0] wr_opts;               // Masked options write

  // Pack the live words; read-only bits forced on every view
  always_comb begin
    words.header  = rom_header_word;
    words.options = (bus_options_word & CRBI_OPT_WR_MASK)
                  | CRBI_OPT_RO_VALUE;
  end

  // ****************************************************************
  // Host write path
  // ****************************************************************
  // Next register values from host writes, soft reset and EEPROM
  always_comb begin
    next_rom_header_word  = rom_header_word;
    next_bus_options_word = bus_options_word;
    wr_opts = (host_req.wdata & CRBI_OPT_WR_MASK)
            | CRBI_OPT_RO_VALUE;
    if (host_req.wr) begin
      unique case (host_req.addr)
        CRBI_OFS_ROM_HEADER: begin
          // Whole word writable: info, crc length, crc value
          next_rom_header_word = host_req.wdata;
        end
        CRBI_OFS_BUS_OPTIONS: begin
          // Flags, accuracy and max_rec taken as written
          next_bus_options_word = wr_opts;
        end
        default: begin
          // Identification and unmapped offsets drop the write
          next_rom_header_word = rom_header_word;
        end
      endcase
    end
    // Soft reset drops capability flags, max_rec keeps its value
    if (soft_rst) begin
      next_bus_options_word = next_bus_options_word
                            & ~CRBI_OPT_FLAG_MASK;
    end
    // EEPROM load wins over a same-cycle host write of the CRC
    if (eeprom_load) begin
      next_rom_header_word[15:0] = eeprom_crc & CRBI_HDR_CRC_MASK;
    end
  end

  // Register the words; CRC resets to zero where left undefined
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rom_header_word  <= CRBI_HDR_RESET;
      bus_options_word <= CRBI_OPT_RESET;
    end else if (ce) begin
      rom_header_word  <= next_rom_header_word;
      bus_options_word <= next_bus_options_word;
    end
  end

  // ****************************************************************
  // Host read path
  // ****************************************************************
  // Read answer one cycle later; unmapped offsets read zero
  always_comb begin
    quad            = crbi_ofs_to_quad(host_req.addr);
    sel             = crbi_quad_sel(quad, words);
    next_host_ack   = host_req.rd | host_req.wr;
    next_host_err   = (host_req.rd | host_req.wr) & ~sel[32];
    next_host_rdata = host_req.rd ? sel[31:0] : 32'h0000_0000;
  end

  // Register host answer and the mirrored words
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      host_rdata      <= 32'h0000_0000;
      host_ack        <= 1'b0;
      host_err        <= 1'b0;
      rom_header_out  <= CRBI_HDR_RESET;
      bus_options_out <= CRBI_OPT_RESET;
    end else if (ce) begin
      host_rdata      <= next_host_rdata;
      host_ack        <= next_host_ack;
      host_err        <= next_host_err;
      // Link side copy used to serve the bus info block
      rom_header_out  <= next_rom_header_word;
      bus_options_out <= (next_bus_options_word & CRBI_OPT_WR_MASK)
                       | CRBI_OPT_RO_VALUE;
    end
  end

  // ****************************************************************
  // Remote configuration ROM reads
  // ****************************************************************
  // Kept apart so the link can read without touching host timing
  crbi_rom_port u_rom_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .ce        (ce),
    .rom_rd    (rom_rd),
    .rom_quad  (rom_quad),
    .words     (words),
    .rom_rdata (rom_rdata),
    .rom_ack   (rom_ack),
    .rom_hit   (rom_hit)
  );

endmodule
`default_nettype wire

// ===== hdl/crbi_pkg.sv
`default_nettype none
package crbi_pkg;

  // ****************************************************************
  // Register offsets on the host side (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CRBI_OFS_ROM_HEADER  = 8'h18;
  localparam logic [7:0] CRBI_OFS_BUS_ID      = 8'h1C;
  localparam logic [7:0] CRBI_OFS_BUS_OPTIONS = 8'h20;

  // ****************************************************************
  // Configuration ROM placement seen by remote nodes
  // ****************************************************************
  localparam logic [47:0] CRBI_ROM_BASE = 48'hFFFF_F000_0400;
  localparam logic [7:0]  CRBI_QUAD_ROM_HEADER  = 8'h00;
  localparam logic [7:0]  CRBI_QUAD_BUS_ID      = 8'h01;
  localparam logic [7:0]  CRBI_QUAD_BUS_OPTIONS = 8'h02;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  localparam logic [31:0] CRBI_BUS_ID_VALUE   = 32'h3133_3934;
  localparam logic [31:0] CRBI_HDR_RESET      = 32'h0000_0000;
  localparam logic [15:0] CRBI_HDR_CRC_MASK   = 16'hFFFF;
  // Writable bits: flags 31-28, accuracy 23-16, max_rec 15-12, 7-6
  localparam logic [31:0] CRBI_OPT_WR_MASK    = 32'hF0FF_F0C0;
  // Read-only bits: 27-24 zero, 11-8 zero, 5-4 zero, 3-0 fixed two
  localparam logic [31:0] CRBI_OPT_RO_VALUE   = 32'h0000_0002;
  localparam logic [31:0] CRBI_OPT_RESET      = 32'h0000_A002;
  // Capability flags cleared by a software reset
  localparam logic [31:0] CRBI_OPT_FLAG_MASK  = 32'hF000_0000;
  localparam int          CRBI_MAXREC_LSB     = 12;
  localparam logic [3:0]  CRBI_MAXREC_2048    = 4'hA;
  localparam logic [3:0]  CRBI_MAXREC_MIN_512 = 4'h8;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [7:0]  addr;   // Byte offset
    logic [31:0] wdata;  // Write data
  } crbi_host_req_t;

  typedef struct packed {
    logic [31:0] header;   // ROM header word
    logic [31:0] options;  // Bus options word
  } crbi_words_t;

  // Select a word by ROM quadlet index; hit flag in bit 32
  function automatic logic [32:0] crbi_quad_sel(input logic [7:0] quad,
                                                input crbi_words_t w);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    unique case (quad)
      CRBI_QUAD_ROM_HEADER:  r = {1'b1, w.header};
      CRBI_QUAD_BUS_ID:      r = {1'b1, CRBI_BUS_ID_VALUE};
      CRBI_QUAD_BUS_OPTIONS: r = {1'b1, w.options};
      default:               r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction

  // Host offset to ROM quadlet index; out of map gives 8'hFF
  function automatic logic [7:0] crbi_ofs_to_quad(input logic [7:0] ofs);
    logic [7:0] q;
    q = 8'hFF;
    unique case (ofs)
      CRBI_OFS_ROM_HEADER:  q = CRBI_QUAD_ROM_HEADER;
      CRBI_OFS_BUS_ID:      q = CRBI_QUAD_BUS_ID;
      CRBI_OFS_BUS_OPTIONS: q = CRBI_QUAD_BUS_OPTIONS;
      default:              q = 8'hFF;
    endcase
    return q;
  endfunction

endpackage
`default_nettype wire

// ===== hdl/crbi_rom_port.sv
`default_nettype none
module crbi_rom_port
  import crbi_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        rom_rd,
  input  wire logic [7:0]  rom_quad,
  input  wire crbi_words_t words,
  output var  logic [31:0] rom_rdata,
  output var  logic        rom_ack,
  output var  logic        rom_hit
);

  // ****************************************************************
  // Remote read answer registers
  // ****************************************************************
  logic [31:0] next_rom_rdata;  // Next answer word
  logic        next_rom_ack;    // Next answer strobe
  logic        next_rom_hit;    // Next hit flag
  logic [32:0] sel;             // Selected word with hit

  // Answer one cycle after the request, live register contents
  always_comb begin
    sel            = crbi_quad_sel(rom_quad, words);
    next_rom_ack   = rom_rd;
    next_rom_rdata = rom_rd ? sel[31:0] : 32'h0000_0000;
    next_rom_hit   = rom_rd & sel[32];
  end

  // Register the answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rom_rdata <= 32'h0000_0000;
      rom_ack   <= 1'b0;
      rom_hit   <= 1'b0;
    end else if (ce) begin
      rom_rdata <= next_rom_rdata;
      rom_ack   <= next_rom_ack;
      rom_hit   <= next_rom_hit;
    end
  end

endmodule
`default_nettype wire

// ===== test/crbi_regs_sva.sv
`default_nettype none
// ********
// Port checker for the register bank
// ********
module crbi_regs_sva
  import crbi_pkg::*;
(
  input wire logic           clock,
  input wire logic           rst_n,
  input wire logic           ce,
  input wire crbi_host_req_t host_req,
  input wire logic [31:0]    host_rdata,
  input wire logic           host_ack,
  input wire logic           host_err,
  input wire logic           soft_rst,
  input wire logic           eeprom_load,
  input wire logic [15:0]    eeprom_crc,
  input wire logic           rom_rd,
  input wire logic [7:0]     rom_quad,
  input wire logic           rom_ack,
  input wire logic           rom_hit,
  input wire logic [31:0]    rom_rdata,
  input wire logic [31:0]    rom_header_out,
  input wire logic [31:0]    bus_options_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A frozen cycle (ce low) excuses the answer
  chk_ack_after_req: assert property (ce && (host_req.rd || host_req.wr)
    |=> !ce || host_ack) else $error("host ack missing");
  chk_id_host_read: assert property (ce && host_req.rd &&
    host_req.addr == CRBI_OFS_BUS_ID
    |=> !ce || host_rdata == CRBI_BUS_ID_VALUE) else $error("bad id read");
  chk_id_rom_read: assert property (ce && rom_rd && rom_quad == 8'h01
    |=> !ce || rom_rdata == CRBI_BUS_ID_VALUE) else $error("bad rom id");
  chk_hdr_rom_mirror: assert property (ce && rom_rd && rom_quad == 8'h00
    |=> !ce || rom_rdata == $past(rom_header_out)) else $error("bad rom hdr");
  chk_opt_ro_bits: assert property (
    (bus_options_out & ~CRBI_OPT_WR_MASK) == CRBI_OPT_RO_VALUE)
    else $error("options read-only bits wrong");
  chk_hdr_write_lands: assert property (ce && host_req.wr && !eeprom_load
    && host_req.addr == CRBI_OFS_ROM_HEADER
    |=> rom_header_out == $past(host_req.wdata)) else $error("hdr write lost");
  chk_eeprom_crc_load: assert property (ce && eeprom_load
    |=> rom_header_out[15:0] == $past(eeprom_crc)) else $error("crc not loaded");
  chk_soft_keep_maxrec: assert property (ce && soft_rst && !host_req.wr
    |=> bus_options_out[15:12] == $past(bus_options_out[15:12]))
    else $error("soft reset moved max request");
  chk_err_unmapped: assert property (ce && (host_req.rd || host_req.wr)
    && host_req.addr != CRBI_OFS_ROM_HEADER
    && host_req.addr != CRBI_OFS_BUS_ID
    && host_req.addr != CRBI_OFS_BUS_OPTIONS
    |=> !ce || host_err) else $error("unmapped access not flagged");
  chk_rom_ack_after_rd: assert property (ce && rom_rd
    |=> !ce || rom_ack) else $error("rom ack missing");
  chk_rom_miss_quiet: assert property (ce && rom_rd
    && rom_quad > CRBI_QUAD_BUS_OPTIONS
    |=> !ce || (!rom_hit && rom_rdata == 32'h0000_0000))
    else $error("rom miss answered");
  chk_opt_rom_mirror: assert property (ce && rom_rd
    && rom_quad == CRBI_QUAD_BUS_OPTIONS
    |=> !ce || rom_rdata == $past(bus_options_out))
    else $error("bad rom options");
  // Hard reset leaves max request at the 2048-byte code
  chk_hard_maxrec: assert property ($rose(rst_n)
    |-> bus_options_out[15:12] == CRBI_MAXREC_2048)
    else $error("max request not reset");
  cov_soft_rst: cover property (ce && soft_rst);
  cov_hdr_write: cover property (ce && host_req.wr);
  cov_rom_read: cover property (ce && rom_rd);
  cov_crc_load: cover property (ce && eeprom_load);
endmodule
`default_nettype wire

// ===== test/crbi_rom_node.sv
`default_nettype none
// ********
// Remote node reading configuration ROM quadlets
// ********
module crbi_rom_node (
  input  wire logic        clock,
  output var  logic        rom_rd,
  output var  logic [7:0]  rom_quad,
  input  wire logic        rom_ack,
  input  wire logic        rom_hit,
  input  wire logic [31:0] rom_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rom_rd = 1'b0;
  initial rom_quad = 8'h00;
  // Idle index is inverted so a stale index never looks valid
  task automatic read_quad(input logic [7:0] q, input int gap,
                           output logic [31:0] d, output logic h);
    int n;
    // At least one edge between two strobes, even with no gap asked
    repeat (gap + 1) @(negedge clock);
    rom_rd = 1'b1;
    rom_quad = q;
    @(negedge clock);
    rom_rd = 1'b0;
    rom_quad = ~q;
    n = 0;
    while (!rom_ack && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = rom_rdata;
    h = rom_hit;
  endtask
endmodule
`default_nettype wire

// ===== test/crbi_regs_tb.sv
`default_nettype none
module crbi_regs_tb
  import crbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // Bench signals
  // ********
  logic           clock = 1'b0;
  logic           rst_n = 1'b0;
  logic           ce = 1'b1; // Dropped once to check the freeze
  crbi_host_req_t req = '0;
  logic           soft_rst = 1'b0;
  logic           eeprom_load = 1'b0;
  logic [15:0]    eeprom_crc = 16'h0000;
  logic           rom_rd, rom_ack, rom_hit, host_ack, host_err, h;
  logic [7:0]     rom_quad;
  logic [31:0]    rom_rdata, host_rdata, d;
  logic [31:0]    hdr = 32'hA5C3_1234;
  int             err_total = 0;
  int             n_tests = 0;
  int             cyc = 0;
  initial forever #50 clock = ~clock;
  crbi_regs u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .host_req(req),
    .host_rdata(host_rdata), .host_ack(host_ack), .host_err(host_err),
    .soft_rst(soft_rst), .eeprom_load(eeprom_load), .eeprom_crc(eeprom_crc),
    .rom_rd(rom_rd), .rom_quad(rom_quad), .rom_rdata(rom_rdata),
    .rom_ack(rom_ack), .rom_hit(rom_hit), .rom_header_out(),
    .bus_options_out());
  crbi_rom_node u_node (.clock(clock), .rom_rd(rom_rd), .rom_quad(rom_quad),
    .rom_ack(rom_ack), .rom_hit(rom_hit), .rom_rdata(rom_rdata));
  // One-bit results: error, hit and ack flags
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // One host cycle; strobe lasts one edge, answer waited for
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(negedge clock);
    req = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(negedge clock);
    req = '0;
    n = 0;
    while (!host_ack && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = host_rdata;
    h = host_err;
  endtask
  task automatic finish_test();
    $display("tests=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    acc(1'b0, CRBI_OFS_ROM_HEADER, 32'h0);
    chk(d, 32'h0000_0000);
    acc(1'b0, CRBI_OFS_BUS_OPTIONS, 32'h0);
    chk(d, 32'h0000_A002);
    acc(1'b1, CRBI_OFS_ROM_HEADER, hdr);
    acc(1'b1, CRBI_OFS_BUS_ID, 32'h0);
    acc(1'b0, CRBI_OFS_BUS_ID, 32'h0);
    chk(d, 32'h3133_3934);
    acc(1'b0, CRBI_OFS_ROM_HEADER, 32'h0);
    chk(d, hdr);
    acc(1'b1, CRBI_OFS_BUS_OPTIONS, 32'hFFFF_FFFF);
    acc(1'b0, CRBI_OFS_BUS_OPTIONS, 32'h0);
    chk(d, 32'hF0FF_F0C2);
    @(negedge clock);
    soft_rst = 1'b1;
    @(negedge clock);
    soft_rst = 1'b0;
    // Soft reset drops the flags only; 27-24 stay read-only zero
    acc(1'b0, CRBI_OFS_BUS_OPTIONS, 32'h0);
    chk(d, 32'h00FF_F0C2);
    eeprom_crc = 16'hBEEF;
    eeprom_load = 1'b1;
    @(negedge clock);
    eeprom_load = 1'b0;
    hdr = {hdr[31:16], 16'hBEEF};
    acc(1'b0, CRBI_OFS_ROM_HEADER, 32'h0);
    chk(d, hdr);
    // Frozen cycle: a header write with the enable low is lost
    @(negedge clock);
    ce = 1'b0;
    req = '{wr: 1'b1, rd: 1'b0, addr: CRBI_OFS_ROM_HEADER,
            wdata: 32'h1111_2222};
    @(negedge clock);
    req = '0;
    ce = 1'b1;
    chk_flag(host_ack, 1'b0);
    acc(1'b0, CRBI_OFS_ROM_HEADER, 32'h0);
    chk(d, hdr);
    acc(1'b0, 8'h24, 32'h0);
    chk_flag(h, 1'b1);
    // Remote side: prompt and slow requests, one index off the map
    u_node.read_quad(8'h00, 0, d, h);
    chk(d, hdr);
    u_node.read_quad(8'h01, 3, d, h);
    chk(d, 32'h3133_3934);
    u_node.read_quad(8'h02, 0, d, h);
    chk(d, 32'h00FF_F0C2);
    u_node.read_quad(8'h03, 1, d, h);
    chk_flag(h, 1'b0);
    chk(d, 32'h0000_0000);
    // Mid-run hard reset restores max request and clears the header
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    acc(1'b0, CRBI_OFS_BUS_OPTIONS, 32'h0);
    chk(d, 32'h0000_A002);
    acc(1'b0, CRBI_OFS_ROM_HEADER, 32'h0);
    chk(d, 32'h0000_0000);
    finish_test();
  end
endmodule
bind crbi_regs crbi_regs_sva u_sva (
  .clock           (clock),
  .rst_n           (rst_n),
  .ce              (ce),
  .host_req        (host_req),
  .host_rdata      (host_rdata),
  .host_ack        (host_ack),
  .host_err        (host_err),
  .soft_rst        (soft_rst),
  .eeprom_load     (eeprom_load),
  .eeprom_crc      (eeprom_crc),
  .rom_rd          (rom_rd),
  .rom_quad        (rom_quad),
  .rom_ack         (rom_ack),
  .rom_hit         (rom_hit),
  .rom_rdata       (rom_rdata),
  .rom_header_out  (rom_header_out),
  .bus_options_out (bus_options_out)
);
`default_nettype wire
